// [sync_check_cfg.svh]
// Constants for the synchronism check close permit: offsets, fields, resets and scales.
// How it works
// - Synchronism means bus and line agree within magnitude, angle and frequency limits.
// - When enabled, manual and reclose requests reach close output only with permit.
// - Closing without synchronism is allowed for the configured dead-source combination.
// - Line voltage magnitude and line frequency are readable values.
// - Line frequency reads zero while line terminal voltage is under 10.0 V.
// - Angle, magnitude and frequency differences are readable values.
// - Bypass selector off means no dead or live combination bypasses the check.
// - Selector picks both dead, line live bus dead, reverse, either dead, or one dead one live.
// - Dead and live thresholds are fractions of each source's nominal voltage.
// - A source is dead when its voltage is below its dead maximum.
// - A source is live when its voltage is above its live minimum.
// - Synchronized only when every difference is below its limit.
`ifndef SYNC_CHECK_CFG_SVH
`define SYNC_CHECK_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL        6'h00
`define OFS_VOLT_LIMIT  6'h04
`define OFS_ANGLE_LIMIT 6'h08
`define OFS_FREQ_LIMIT  6'h0c
`define OFS_BUS_NOM     6'h10
`define OFS_LINE_NOM    6'h14
`define OFS_DEAD_BUS    6'h18
`define OFS_DEAD_LINE   6'h1c
`define OFS_LIVE_BUS    6'h20
`define OFS_LIVE_LINE   6'h24
`define OFS_LINE_VOLT   6'h28
`define OFS_LINE_FREQ   6'h2c
`define OFS_VOLT_DIFF   6'h30
`define OFS_ANGLE_DIFF  6'h34
`define OFS_FREQ_DIFF   6'h38
`define OFS_STATUS      6'h3c

// ****************************************
// Fields, reset values and scales
// ****************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_SEL_LSB    1
`define CTRL_SEL_MSB    3
`define RST_VOLT_LIMIT  16'h03e8
`define RST_ANGLE_LIMIT 9'h014
`define RST_FREQ_LIMIT  16'h0032
`define RST_NOMINAL     16'h2ee0
`define RST_DEAD_MAX    16'h012c
`define RST_LIVE_MIN    16'h0320
`define FRAC_SCALE      32'h0000_03e8
`define FREQ_MIN_VOLT   16'h03e8
`define HALF_TURN       9'h0b4
`define FULL_TURN       9'h168

`endif

// [sync_check_pkg.sv]
// Types shared by the synchronism check modules.
package sync_check_pkg;

  // Dead-source bypass selections, in selector order.
  typedef enum logic [2:0] {
    bypass_off,
    both_dead_bypass,
    line_live_bus_dead_bypass,
    line_dead_bus_live_bypass,
    either_dead_bypass,
    one_dead_one_live_bypass
  } bypass_type;

  typedef logic [15:0] volt_type;
  typedef logic [8:0]  angle_type;
  typedef logic [15:0] freq_type;

endpackage : sync_check_pkg

// [sample_diff_if.sv]
// Carrier for the registered sample and its differences between the two modules.
interface sample_diff_if;
  import sync_check_pkg::*;

  logic      valid;
  volt_type  bus_volt;
  volt_type  line_volt;
  freq_type  line_freq;
  volt_type  volt_diff;
  angle_type angle_diff;
  freq_type  freq_diff;

  modport producer (output valid, bus_volt, line_volt, line_freq, volt_diff, angle_diff,
                    freq_diff);
  modport consumer (input valid, bus_volt, line_volt, line_freq, volt_diff, angle_diff,
                    freq_diff);
endinterface : sample_diff_if

// [sample_diff.sv]
// Captures each measurement sample and forms the absolute differences between the sources.
`include "sync_check_cfg.svh"
module sample_diff
  import sync_check_pkg::*;
(
  input  wire logic      clock_i,
  input  wire logic      rst_i,
  input  wire logic      sample_i,
  input  wire volt_type  bus_volt_i,
  input  wire volt_type  line_volt_i,
  input  wire angle_type bus_angle_i,
  input  wire angle_type line_angle_i,
  input  wire freq_type  bus_freq_i,
  input  wire freq_type  line_freq_i,
  sample_diff_if.producer res
);

  angle_type raw_angle;
  angle_type next_angle;

  // The shorter way round the circle is the true phase separation.
  always_comb
  begin
    raw_angle  = (bus_angle_i >= line_angle_i) ? bus_angle_i - line_angle_i
                                               : line_angle_i - bus_angle_i;
    next_angle = (raw_angle > `HALF_TURN) ? `FULL_TURN - raw_angle : raw_angle;
  end

  // ****************************************
  // Sample capture
  // ****************************************
  // Differences are stored with the sample so both stay consistent until the next one.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      res.valid      <= 1'b0;
      res.bus_volt   <= '0;
      res.line_volt  <= '0;
      res.line_freq  <= '0;
      res.volt_diff  <= '0;
      res.angle_diff <= '0;
      res.freq_diff  <= '0;
    end
    else
    begin
      res.valid <= sample_i;
      if (sample_i)
      begin
        res.bus_volt   <= bus_volt_i;
        res.line_volt  <= line_volt_i;
        res.line_freq  <= line_freq_i;
        res.volt_diff  <= (bus_volt_i >= line_volt_i) ? bus_volt_i - line_volt_i
                                                      : line_volt_i - bus_volt_i;
        res.angle_diff <= next_angle;
        res.freq_diff  <= (bus_freq_i >= line_freq_i) ? bus_freq_i - line_freq_i
                                                      : line_freq_i - bus_freq_i;
      end
    end
  end

  chk_angle_half_turn: assert property (@(posedge clock_i) disable iff (rst_i)
    res.valid |-> res.angle_diff <= `HALF_TURN)
    else $error("Angle difference exceeds half a turn.");

  chk_sample_to_valid: assert property (@(posedge clock_i) disable iff (rst_i)
    sample_i |=> res.valid && res.line_volt == $past(line_volt_i))
    else $error("Sample was not captured on the following edge.");

endmodule : sample_diff

// [sync_check_close_permit.sv]
// Synchronism check with dead-source bypass gating breaker close requests, AHB-Lite registers.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`include "sync_check_cfg.svh"
module sync_check_close_permit
  import sync_check_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        sample_i,
  input  wire volt_type    bus_volt_i,
  input  wire volt_type    line_volt_i,
  input  wire angle_type   bus_angle_i,
  input  wire angle_type   line_angle_i,
  input  wire freq_type    bus_freq_i,
  input  wire freq_type    line_freq_i,
  input  wire logic        manual_close_i,
  input  wire logic        reclose_i,
  output logic             close_o,
  output logic             permit_o
);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic      enable;
  logic [2:0] bypass_sel;
  volt_type  volt_limit;
  angle_type angle_limit;
  freq_type  freq_limit;
  volt_type  bus_nom;
  volt_type  line_nom;
  logic [15:0] dead_bus_max;
  logic [15:0] dead_line_max;
  logic [15:0] live_bus_min;
  logic [15:0] live_line_min;

  // Bus data phase state.
  logic       wr_pend;
  logic [5:0] wr_addr;
  logic [31:0] next_rdata;

  // Evaluation state.
  logic bus_dead;
  logic bus_live;
  logic line_dead;
  logic line_live;
  logic synced;
  logic bypass;
  logic permit;

  sample_diff_if res ();

  sample_diff sample_diff_inst (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .sample_i     (sample_i),
    .bus_volt_i   (bus_volt_i),
    .line_volt_i  (line_volt_i),
    .bus_angle_i  (bus_angle_i),
    .line_angle_i (line_angle_i),
    .bus_freq_i   (bus_freq_i),
    .line_freq_i  (line_freq_i),
    .res          (res.producer)
  );

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Zero wait states; the slave never errors, unmapped words read zero and ignore writes.
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Address phase: latch a write for the data phase.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end
    else if (hready_i)
    begin
      wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
      wr_addr <= haddr_i[5:0];
    end
  end

  // Data phase write into the configuration registers.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      enable        <= 1'b0;
      bypass_sel    <= 3'h0;
      volt_limit    <= `RST_VOLT_LIMIT;
      angle_limit   <= `RST_ANGLE_LIMIT;
      freq_limit    <= `RST_FREQ_LIMIT;
      bus_nom       <= `RST_NOMINAL;
      line_nom      <= `RST_NOMINAL;
      dead_bus_max  <= `RST_DEAD_MAX;
      dead_line_max <= `RST_DEAD_MAX;
      live_bus_min  <= `RST_LIVE_MIN;
      live_line_min <= `RST_LIVE_MIN;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        `OFS_CTRL:
        begin
          enable     <= hwdata_i[`CTRL_ENABLE_BIT];
          bypass_sel <= hwdata_i[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
        end
        `OFS_VOLT_LIMIT:  volt_limit    <= hwdata_i[15:0];
        `OFS_ANGLE_LIMIT: angle_limit   <= hwdata_i[8:0];
        `OFS_FREQ_LIMIT:  freq_limit    <= hwdata_i[15:0];
        `OFS_BUS_NOM:     bus_nom       <= hwdata_i[15:0];
        `OFS_LINE_NOM:    line_nom      <= hwdata_i[15:0];
        `OFS_DEAD_BUS:    dead_bus_max  <= hwdata_i[15:0];
        `OFS_DEAD_LINE:   dead_line_max <= hwdata_i[15:0];
        `OFS_LIVE_BUS:    live_bus_min  <= hwdata_i[15:0];
        `OFS_LIVE_LINE:   live_line_min <= hwdata_i[15:0];
        default:          enable        <= enable;
      endcase
    end
  end

  // Read mux, evaluated in the address phase so data stands in the data phase.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (haddr_i[5:0])
      `OFS_CTRL:        next_rdata = {28'h0, bypass_sel, enable};
      `OFS_VOLT_LIMIT:  next_rdata = {16'h0, volt_limit};
      `OFS_ANGLE_LIMIT: next_rdata = {23'h0, angle_limit};
      `OFS_FREQ_LIMIT:  next_rdata = {16'h0, freq_limit};
      `OFS_BUS_NOM:     next_rdata = {16'h0, bus_nom};
      `OFS_LINE_NOM:    next_rdata = {16'h0, line_nom};
      `OFS_DEAD_BUS:    next_rdata = {16'h0, dead_bus_max};
      `OFS_DEAD_LINE:   next_rdata = {16'h0, dead_line_max};
      `OFS_LIVE_BUS:    next_rdata = {16'h0, live_bus_min};
      `OFS_LIVE_LINE:   next_rdata = {16'h0, live_line_min};
      `OFS_LINE_VOLT:   next_rdata = {16'h0, res.line_volt};
      `OFS_LINE_FREQ:
      begin
        // Frequency from a nearly absent voltage is noise, so it is hidden.
        if (res.line_volt >= `FREQ_MIN_VOLT)
          next_rdata = {16'h0, res.line_freq};
      end
      `OFS_VOLT_DIFF:   next_rdata = {16'h0, res.volt_diff};
      `OFS_ANGLE_DIFF:  next_rdata = {23'h0, res.angle_diff};
      `OFS_FREQ_DIFF:   next_rdata = {16'h0, res.freq_diff};
      `OFS_STATUS:      next_rdata = {26'h0, line_live, line_dead, bus_live, bus_dead,
                                      synced, permit};
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is registered so that it stands through the whole data phase.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      hrdata_o <= 32'h0000_0000;
    else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
      hrdata_o <= next_rdata;
  end

  // ****************************************
  // Source classification and synchronism
  // ****************************************
  // Thresholds are thousandths of nominal; cross-multiplying avoids any divider.
  always_comb
  begin
    bus_dead  = {16'h0, res.bus_volt} * `FRAC_SCALE < {16'h0, dead_bus_max} * {16'h0, bus_nom};
    line_dead = {16'h0, res.line_volt} * `FRAC_SCALE
                < {16'h0, dead_line_max} * {16'h0, line_nom};
    bus_live  = {16'h0, res.bus_volt} * `FRAC_SCALE > {16'h0, live_bus_min} * {16'h0, bus_nom};
    line_live = {16'h0, res.line_volt} * `FRAC_SCALE
                > {16'h0, live_line_min} * {16'h0, line_nom};
  end

  // Each limit is strict: a difference equal to its limit is out of synchronism.
  assign synced = (res.volt_diff < volt_limit) && (res.angle_diff < angle_limit)
                  && (res.freq_diff < freq_limit);

  // A source in the band between thresholds sets neither flag and satisfies nothing.
  always_comb
  begin
    case (bypass_type'(bypass_sel))
      bypass_off:                bypass = 1'b0;
      both_dead_bypass:          bypass = bus_dead && line_dead;
      line_live_bus_dead_bypass: bypass = line_live && bus_dead;
      line_dead_bus_live_bypass: bypass = line_dead && bus_live;
      either_dead_bypass:        bypass = line_dead || bus_dead;
      one_dead_one_live_bypass:  bypass = (line_dead && bus_live) || (line_live && bus_dead);
      default:                   bypass = 1'b0;
    endcase
  end

  // ****************************************
  // Permit and close gating
  // ****************************************
  // The permit holds between samples and is refreshed on each one.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      permit <= 1'b0;
    else if (res.valid)
      permit <= synced || bypass;
  end

  assign permit_o = permit;

  // Requests pass straight through when the function is disabled.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      close_o <= 1'b0;
    else
      close_o <= (manual_close_i || reclose_i) && (!enable || permit);
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_close_needs_permit: assert property (@(posedge clock_i) disable iff (rst_i)
    close_o |-> $past(!enable || permit) && $past(manual_close_i || reclose_i))
    else $error("Close driven without permit or request.");

  chk_disabled_passes: assert property (@(posedge clock_i) disable iff (rst_i)
    (!enable && reclose_i) |=> close_o)
    else $error("Reclose blocked while function disabled.");

  chk_off_no_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
    bypass_sel == 3'h0 |-> !bypass)
    else $error("Bypass active with selector off.");

  chk_both_dead_only: assert property (@(posedge clock_i) disable iff (rst_i)
    (bypass_sel == 3'h1 && bypass) |-> (bus_dead && line_dead))
    else $error("Both-dead bypass without two dead sources.");

  chk_sync_in_limits: assert property (@(posedge clock_i) disable iff (rst_i)
    synced |-> res.volt_diff < volt_limit && res.freq_diff < freq_limit
               && res.angle_diff < angle_limit)
    else $error("Synchronism declared outside limits.");

  chk_permit_follows: assert property (@(posedge clock_i) disable iff (rst_i)
    res.valid |=> permit == $past(synced || bypass))
    else $error("Permit not refreshed from sample.");

  chk_permit_holds: assert property (@(posedge clock_i) disable iff (rst_i)
    !res.valid |=> $stable(permit))
    else $error("Permit changed without a sample.");

  chk_freq_hidden: assert property (@(posedge clock_i) disable iff (rst_i)
    (hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[5:0] == `OFS_LINE_FREQ
     && res.line_volt < `FREQ_MIN_VOLT) |=> hrdata_o == 32'h0000_0000)
    else $error("Line frequency shown below minimum voltage.");

  // Each remaining selector value admits only its own combination of source states.
  chk_live_line_sel: assert property (@(posedge clock_i) disable iff (rst_i)
    bypass_sel == 3'h2 |-> bypass == (line_live && bus_dead))
    else $error("Live line dead bus bypass mismatch.");

  chk_dead_line_sel: assert property (@(posedge clock_i) disable iff (rst_i)
    bypass_sel == 3'h3 |-> bypass == (line_dead && bus_live))
    else $error("Dead line live bus bypass mismatch.");

  chk_either_dead_sel: assert property (@(posedge clock_i) disable iff (rst_i)
    bypass_sel == 3'h4 |-> bypass == (line_dead || bus_dead))
    else $error("Either dead bypass mismatch.");

  chk_one_dead_sel: assert property (@(posedge clock_i) disable iff (rst_i)
    bypass_sel == 3'h5 |-> bypass == ((line_dead && bus_live) || (line_live && bus_dead)))
    else $error("One dead one live bypass mismatch.");

  chk_spare_sel_off: assert property (@(posedge clock_i) disable iff (rst_i)
    bypass_sel > 3'h5 |-> !bypass)
    else $error("Bypass active with a spare selector value.");

  // With sane thresholds a source can never be dead and live at once.
  chk_bus_state_excl: assert property (@(posedge clock_i) disable iff (rst_i)
    (dead_bus_max <= live_bus_min) |-> !(bus_dead && bus_live))
    else $error("Bus source both dead and live.");

  chk_line_state_excl: assert property (@(posedge clock_i) disable iff (rst_i)
    (dead_line_max <= live_line_min) |-> !(line_dead && line_live))
    else $error("Line source both dead and live.");

  chk_close_allowed: assert property (@(posedge clock_i) disable iff (rst_i)
    (enable && permit && (manual_close_i || reclose_i)) |=> close_o)
    else $error("Permitted close request did not reach the output.");

  chk_idle_no_close: assert property (@(posedge clock_i) disable iff (rst_i)
    !(manual_close_i || reclose_i) |=> !close_o)
    else $error("Close driven without any request.");

  chk_disabled_manual: assert property (@(posedge clock_i) disable iff (rst_i)
    (!enable && manual_close_i) |=> close_o)
    else $error("Manual close blocked while function disabled.");

endmodule : sync_check_close_permit

// [meas_source.sv]
// Behavioural measurement source that feeds sample pulses to the close permit block.
module meas_source
  import sync_check_pkg::*;
(
  input  wire logic clock_i,
  output logic      sample_o,
  output volt_type  bus_volt_o,
  output volt_type  line_volt_o,
  output angle_type bus_angle_o,
  output angle_type line_angle_o,
  output freq_type  bus_freq_o,
  output freq_type  line_freq_o
);
  // Quiet start; both sources are phase to neutral, so no delta bus feed is modelled.
  initial
  begin
    sample_o     = 1'b0;
    bus_volt_o   = 16'h0000;
    line_volt_o  = 16'h0000;
    bus_angle_o  = 9'h000;
    line_angle_o = 9'h000;
    bus_freq_o   = 16'h0000;
    line_freq_o  = 16'h0000;
  end

  // One sample pulse; the values stand as levels until the next sample replaces them.
  task automatic send(input int bv, input int lv, input int ba, input int la, input int bf,
                      input int lf);
    @(posedge clock_i);
    sample_o     <= 1'b1;
    bus_volt_o   <= bv[15:0];
    line_volt_o  <= lv[15:0];
    bus_angle_o  <= ba[8:0];
    line_angle_o <= la[8:0];
    bus_freq_o   <= bf[15:0];
    line_freq_o  <= lf[15:0];
    @(posedge clock_i);
    sample_o <= 1'b0;
  endtask : send
endmodule : meas_source

// [test_sync_check_close_permit.sv]
// Self-checking bench for the synchronism check close permit block.
`include "sync_check_cfg.svh"
module test_sync_check_close_permit;
  timeunit 1ns;
  timeprecision 1ps;
  import sync_check_pkg::*;

  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        manual  = 1'b0;
  logic        reclose = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        close;
  logic        permit;
  logic        sample;
  volt_type    bus_volt, line_volt;
  angle_type   bus_angle, line_angle;
  freq_type    bus_freq, line_freq;
  int          err_total   = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  sync_check_close_permit sync_check_close_permit_inst (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .sample_i(sample),
    .bus_volt_i(bus_volt), .line_volt_i(line_volt), .bus_angle_i(bus_angle),
    .line_angle_i(line_angle), .bus_freq_i(bus_freq), .line_freq_i(line_freq),
    .manual_close_i(manual), .reclose_i(reclose), .close_o(close), .permit_o(permit));

  meas_source meas_source_inst (
    .clock_i(clock_i), .sample_o(sample), .bus_volt_o(bus_volt), .line_volt_o(line_volt),
    .bus_angle_o(bus_angle), .line_angle_o(line_angle), .bus_freq_o(bus_freq),
    .line_freq_o(line_freq));

  // ****
  // Clock, timeout and shared tasks
  // ****
  // Clock toggles every 10 ns, a period of 20 ns.
  always #10 clock_i = ~clock_i;

  // Cut a hang short; the whole run needs well under this many cycles.
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d.", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Single word transfer; read data is taken at the edge that ends the data phase.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock_i);
    hsel   <= 1'b1;
    haddr  <= {26'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock_i);
    while (hready !== 1'b1)
      @(posedge clock_i);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock_i);
    while (hready !== 1'b1)
      @(posedge clock_i);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp, what);
  endtask : rd_chk

  // The permit lands two edges after the sample edge.
  task automatic meas(input int bv, input int lv, input int ba, input int la, input int bf,
                      input int lf);
    meas_source_inst.send(bv, lv, ba, la, bf, lf);
    repeat (2) @(posedge clock_i);
    #1;
  endtask : meas

  // Expected status from the default thresholds: dead below 3600, live above 9600.
  function automatic logic [31:0] status_exp(input int sel, input int bv, input int lv);
    logic bd, bl, ld, ll, p;
    bd = (bv * 1000 < 300 * 12000);
    bl = (bv * 1000 > 800 * 12000);
    ld = (lv * 1000 < 300 * 12000);
    ll = (lv * 1000 > 800 * 12000);
    case (sel)
      1: p = bd & ld;
      2: p = ll & bd;
      3: p = ld & bl;
      4: p = ld | bd;
      5: p = (ld & bl) | (bd & ll);
      default: p = 1'b0;
    endcase
    return {26'h0, ll, ld, bl, bd, 1'b0, p};
  endfunction : status_exp

  // ****
  // Scenarios
  // ****
  task automatic reset_values();
    chk(permit, 1'b0, "permit after reset");
    chk(close, 1'b0, "close after reset");
    chk(hresp, 1'b0, "okay response");
    rd_chk(`OFS_CTRL, 32'h0, "ctrl");
    rd_chk(`OFS_VOLT_LIMIT, `RST_VOLT_LIMIT, "volt limit");
    rd_chk(`OFS_ANGLE_LIMIT, `RST_ANGLE_LIMIT, "angle limit");
    rd_chk(`OFS_FREQ_LIMIT, `RST_FREQ_LIMIT, "freq limit");
    rd_chk(`OFS_LINE_NOM, `RST_NOMINAL, "line nominal");
    rd_chk(`OFS_DEAD_LINE, `RST_DEAD_MAX, "dead line max");
    rd_chk(`OFS_LIVE_BUS, `RST_LIVE_MIN, "live bus min");
  endtask : reset_values

  // Close requests with the function on, blocked and disabled.
  task automatic close_try(input logic m, input logic r, input logic exp);
    @(posedge clock_i);
    manual  <= m;
    reclose <= r;
    @(posedge clock_i);
    manual  <= 1'b0;
    reclose <= 1'b0;
    #1;
    chk(close, exp, "close while requested");
    @(posedge clock_i);
    #1;
    chk(close, 1'b0, "close after release");
  endtask : close_try

  task automatic sync_limits();
    int t[5][7] = '{'{12000, 12000, 0, 0, 6000, 6000, 1}, '{12000, 11000, 0, 0, 6000, 6000, 0},
                    '{12000, 12000, 350, 10, 6000, 6000, 0},
                    '{12000, 12000, 0, 0, 6000, 6050, 0},
                    '{12000, 11001, 355, 14, 6000, 6049, 1}};
    wr(`OFS_CTRL, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      meas(t[i][0], t[i][1], t[i][2], t[i][3], t[i][4], t[i][5]);
      chk(permit, t[i][6], "permit at limit edge");
      close_try(1'b1, 1'b0, t[i][6][0]);
      close_try(1'b0, 1'b1, t[i][6][0]);
    end
    rd_chk(`OFS_LINE_VOLT, 32'd11001, "line volt");
    rd_chk(`OFS_LINE_FREQ, 32'd6049, "line freq");
    rd_chk(`OFS_VOLT_DIFF, 32'd999, "volt diff");
    rd_chk(`OFS_ANGLE_DIFF, 32'd19, "angle diff");
    rd_chk(`OFS_FREQ_DIFF, 32'd49, "freq diff");
    wr(`OFS_LINE_VOLT, 32'hffff_ffff);
    rd_chk(`OFS_LINE_VOLT, 32'd11001, "read only line volt");
    rd_chk(`OFS_STATUS, 32'h2b, "status synced");
    meas(12000, 999, 0, 0, 6000, 6000);
    rd_chk(`OFS_LINE_FREQ, 32'h0, "freq below 10 V");
    meas(12000, 1000, 0, 0, 6000, 6000);
    rd_chk(`OFS_LINE_FREQ, 32'd6000, "freq at 10 V");
    wr(`OFS_CTRL, 32'h0);
    close_try(1'b1, 1'b0, 1'b1);
  endtask : sync_limits

  // Every selector value against dead, middle and live sources at the threshold edges.
  task automatic bypass_table();
    int v[6] = '{100, 3599, 3600, 9600, 9601, 12000};
    logic [31:0] r;
    for (int sel = 0; sel < 8; sel++)
    begin
      wr(`OFS_CTRL, {28'h0, sel[2:0], 1'b1});
      for (int b = 0; b < 6; b++)
        for (int l = 0; l < 6; l++)
        begin
          meas(v[b], v[l], 0, 90, 6000, 6000);
          chk(permit, status_exp(sel, v[b], v[l]) & 32'h1, "bypass permit");
          bus(1'b0, `OFS_STATUS, 32'h0, r);
          chk(r, status_exp(sel, v[b], v[l]), "dead live status");
        end
    end
    wr(`OFS_CTRL, 32'h3);
    wr(`OFS_BUS_NOM, 32'd6000);
    meas(1799, 100, 0, 90, 6000, 6000);
    chk(permit, 1'b1, "dead bus on half nominal");
    meas(1800, 100, 0, 90, 6000, 6000);
    chk(permit, 1'b0, "bus not dead at threshold");
    close_try(1'b1, 1'b1, 1'b0);
  endtask : bypass_table

  // Main sequence: reset for 20 cycles, then the scenarios.
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    reset_values();
    sync_limits();
    bypass_table();
    end_sim();
  end
endmodule : test_sync_check_close_permit
